// File: include/pfm_defines.svh
// Constants of the port pin function matrix: pin indices, function codes, idle levels.
// Contract
// - Port 0 pins 0-3 primary UART0 A rx/tx/cts/rts; secondary UART0 B tx/rx/rts/cts.
// - Port 1 pins 0-5 SPI master 1 clock/lanes/select0; secondary same roles for XIP.
// - Port 1 pins 6-7 carry I2C master 0 and slave option A data/clock only.
// - Port 2 pins 0-3 mirror port 0 for UART1, options A and B.
// - Port 3 pins 0-3 mirror port 0 for UART2, options A and B.
// - Port 3 pins 4-5 I2C master 1 / slave B; secondary SPI master 2 select1, select2.
// - Port 3 pins 6-7 SPI master 1 select1/2; secondary XIP select1/2.
// - Port 4 pin 0 single-wire line, pin 1 pull-up enable; secondary slave-ready 0/1.
// - Pulse-train outputs 0-15 repeat over ports 0-1, 2-3, restart on port 4.
// - Timer slots cycle timers 0-5 in pin order, wrapping after timer 5.
// - Each port has its own interrupt line fed by all its pins.
// - Pin configuration chooses whether I2C master or slave owns shared pins.
// - Every pin independently selects general-purpose or special-function operation.
// - Peripheral signals follow the selected lettered pin option.
// - Any pin may output its pulse-train output or its 32-bit timer output.
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

`define PFM_NUM_PINS   34
`define PFM_NUM_PORTS  5
`define PFM_PORT_PINS  8
`define PFM_PORT0      0
`define PFM_PORT1      8
`define PFM_PORT2      16
`define PFM_PORT3      24
`define PFM_PORT4      32
`define PFM_PT_SLOTS   16
`define PFM_TMR_SLOTS  6

// Pins that own a secondary function.
`define PFM_SEC_MASK   34'h3_ff0f_3f0f

// Per-pin function codes.
`define PFM_MODE_GPIO  3'h0
`define PFM_MODE_PRI   3'h1
`define PFM_MODE_SEC   3'h2
`define PFM_MODE_PT    3'h3
`define PFM_MODE_TOUT  3'h4
`define PFM_MODE_TIN   3'h5

// Levels given to a peripheral input when no pin is routed to it.
`define PFM_IDLE_RX    1'h1
`define PFM_IDLE_CTS   1'h1
`define PFM_IDLE_I2C   1'h1
`define PFM_IDLE_SWM   1'h1
`define PFM_IDLE_LANE  1'h0
`define PFM_IDLE_SR    1'h0
`define PFM_IDLE_TMR   1'h0

`endif

// File: include/pfm_pkg.sv
// Types shared by the port pin function matrix modules.
package pfm_pkg;

    typedef struct packed {
        logic tx;
        logic rts;
    } pfm_uart_out_t;

    typedef struct packed {
        logic rx;
        logic cts;
    } pfm_uart_in_t;

    typedef struct packed {
        logic       clock;
        logic [2:0] select;
        logic [3:0] lane_out;
        logic [3:0] lane_oe;
    } pfm_spi_out_t;

    typedef struct packed {
        logic [3:0] lane_in;
        logic [1:0] slave_ready;
    } pfm_spi_in_t;

    typedef struct packed {
        logic data_pull;
        logic clock_pull;
    } pfm_i2c_out_t;

    typedef struct packed {
        logic data;
        logic clock;
    } pfm_i2c_in_t;

    typedef struct packed {
        logic line_pull;
        logic pullup_enable;
    } pfm_swm_out_t;

    typedef struct packed {
        logic [33:0]             pad_out;
        logic [33:0]             pad_oe_n;
        pfm_uart_in_t [2:0]      uart_in;
        pfm_spi_in_t [2:0]       spim_in;
        pfm_spi_in_t             xip_in;
        pfm_i2c_in_t [1:0]       i2cm_in;
        pfm_i2c_in_t             i2cs_in;
        logic                    swm_in;
        logic [5:0]              timer_in;
        logic [4:0]              port_irq;
    } pfm_state_t;

endpackage : pfm_pkg

// File: verilog/pfm_pin_cell.sv
// One pin's function selector: picks the driver of the pad from the pin's function code.
`include "pfm_defines.svh"

module pfm_pin_cell (
    input  wire logic [2:0] mode,
    input  wire logic       has_sec,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    input  wire logic       pri_out,
    input  wire logic       pri_oe,
    input  wire logic       sec_out,
    input  wire logic       sec_oe,
    input  wire logic       pt_out,
    input  wire logic       tmr_out,
    output logic            drv_out,
    output logic            drv_oe,
    output logic            pri_on,
    output logic            sec_on,
    output logic            tin_on
);

    // Unknown codes and a secondary request on a pin without one fall back to general purpose.
    always_comb begin
        drv_out = gpio_out;
        drv_oe  = gpio_oe;
        pri_on  = 1'b0;
        sec_on  = 1'b0;
        tin_on  = 1'b0;
        case (mode)
            `PFM_MODE_PRI: begin
                drv_out = pri_out;
                drv_oe  = pri_oe;
                pri_on  = 1'b1;
            end
            `PFM_MODE_SEC: begin
                if (has_sec) begin
                    drv_out = sec_out;
                    drv_oe  = sec_oe;
                    sec_on  = 1'b1;
                end
            end
            `PFM_MODE_PT: begin
                drv_out = pt_out;
                drv_oe  = 1'b1;
            end
            `PFM_MODE_TOUT: begin
                drv_out = tmr_out;
                drv_oe  = 1'b1;
            end
            `PFM_MODE_TIN: begin
                drv_oe  = 1'b0;
                tin_on  = 1'b1;
            end
            default: begin
                drv_out = gpio_out;
                drv_oe  = gpio_oe;
            end
        endcase
    end

endmodule : pfm_pin_cell

// File: verilog/pfm_matrix.sv
// Port pin function matrix: routes peripheral signals to and from the 34 port pins.
`include "pfm_defines.svh"

module pfm_matrix (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [33:0]                 pad_in,
    output logic [33:0]                      pad_out,
    output logic [33:0]                      pad_oe_n,
    input  wire logic [33:0][2:0]            pin_mode,
    input  wire logic [33:0]                 gpio_out,
    input  wire logic [33:0]                 gpio_oe,
    input  wire logic [33:0]                 irq_enable,
    input  wire logic                        i2c_slave_select_a,
    input  wire logic                        i2c_slave_select_b,
    input  wire pfm_pkg::pfm_uart_out_t [2:0] uart_out,
    output pfm_pkg::pfm_uart_in_t [2:0]      uart_in,
    input  wire pfm_pkg::pfm_spi_out_t [2:0] spim_out,
    output pfm_pkg::pfm_spi_in_t [2:0]       spim_in,
    input  wire pfm_pkg::pfm_spi_out_t       xip_out,
    output pfm_pkg::pfm_spi_in_t             xip_in,
    input  wire pfm_pkg::pfm_i2c_out_t [1:0] i2cm_out,
    output pfm_pkg::pfm_i2c_in_t [1:0]       i2cm_in,
    input  wire pfm_pkg::pfm_i2c_out_t       i2cs_out,
    output pfm_pkg::pfm_i2c_in_t             i2cs_in,
    input  wire pfm_pkg::pfm_swm_out_t       swm_out,
    output logic                             swm_in,
    input  wire logic [15:0]                 pt_out,
    input  wire logic [5:0]                  timer_out,
    output logic [5:0]                       timer_in,
    output logic [4:0]                       port_irq
);

    pfm_pkg::pfm_state_t state_reg;
    pfm_pkg::pfm_state_t state_next;

    logic [33:0] pri_out;
    logic [33:0] pri_oe;
    logic [33:0] sec_out;
    logic [33:0] sec_oe;
    logic [33:0] drv_out;
    logic [33:0] drv_oe;
    logic [33:0] pri_on;
    logic [33:0] sec_on;
    logic [33:0] tin_on;

    // UART ports 0, 2 and 3: option A rx/tx/cts/rts, option B tx/rx/rts/cts.
    localparam int UART_BASE [3] = '{`PFM_PORT0, `PFM_PORT2, `PFM_PORT3};

    // Pins that own a secondary function; a vector, so that each selector takes just its own bit.
    localparam logic [33:0] SEC_MASK = `PFM_SEC_MASK;

    // Primary and secondary drivers of each pin; inputs and unused pins never drive.
    always_comb begin
        pri_out = '0;
        pri_oe  = '0;
        sec_out = '0;
        sec_oe  = '0;
        for (int u = 0; u < 3; u++) begin
            pri_out[UART_BASE[u] + 1] = uart_out[u].tx;
            pri_oe[UART_BASE[u] + 1]  = 1'b1;
            pri_out[UART_BASE[u] + 3] = uart_out[u].rts;
            pri_oe[UART_BASE[u] + 3]  = 1'b1;
            sec_out[UART_BASE[u] + 0] = uart_out[u].tx;
            sec_oe[UART_BASE[u] + 0]  = 1'b1;
            sec_out[UART_BASE[u] + 2] = uart_out[u].rts;
            sec_oe[UART_BASE[u] + 2]  = 1'b1;
        end
        // Four-wire SPI masters 0 and 2 on ports 0 and 2.
        pri_out[`PFM_PORT0 + 4] = spim_out[0].clock;
        pri_oe[`PFM_PORT0 + 4]  = 1'b1;
        pri_out[`PFM_PORT0 + 5] = spim_out[0].lane_out[0];
        pri_oe[`PFM_PORT0 + 5]  = spim_out[0].lane_oe[0];
        pri_out[`PFM_PORT0 + 6] = spim_out[0].lane_out[1];
        pri_oe[`PFM_PORT0 + 6]  = spim_out[0].lane_oe[1];
        pri_out[`PFM_PORT0 + 7] = spim_out[0].select[0];
        pri_oe[`PFM_PORT0 + 7]  = 1'b1;
        pri_out[`PFM_PORT2 + 4] = spim_out[2].clock;
        pri_oe[`PFM_PORT2 + 4]  = 1'b1;
        pri_out[`PFM_PORT2 + 5] = spim_out[2].lane_out[0];
        pri_oe[`PFM_PORT2 + 5]  = spim_out[2].lane_oe[0];
        pri_out[`PFM_PORT2 + 6] = spim_out[2].lane_out[1];
        pri_oe[`PFM_PORT2 + 6]  = spim_out[2].lane_oe[1];
        pri_out[`PFM_PORT2 + 7] = spim_out[2].select[0];
        pri_oe[`PFM_PORT2 + 7]  = 1'b1;
        // Quad SPI master 1 and the execute-in-place master share port 1 pins 0 to 5.
        pri_out[`PFM_PORT1 + 0] = spim_out[1].clock;
        pri_oe[`PFM_PORT1 + 0]  = 1'b1;
        pri_out[`PFM_PORT1 + 3] = spim_out[1].select[0];
        pri_oe[`PFM_PORT1 + 3]  = 1'b1;
        sec_out[`PFM_PORT1 + 0] = xip_out.clock;
        sec_oe[`PFM_PORT1 + 0]  = 1'b1;
        sec_out[`PFM_PORT1 + 3] = xip_out.select[0];
        sec_oe[`PFM_PORT1 + 3]  = 1'b1;
        for (int l = 0; l < 4; l++) begin
            pri_out[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)] = spim_out[1].lane_out[l];
            pri_oe[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)]  = spim_out[1].lane_oe[l];
            sec_out[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)] = xip_out.lane_out[l];
            sec_oe[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)]  = xip_out.lane_oe[l];
        end
        // I2C is open drain: the pad only ever pulls low, the owner is chosen by configuration.
        pri_oe[`PFM_PORT1 + 6] = i2c_slave_select_a ? i2cs_out.data_pull : i2cm_out[0].data_pull;
        pri_oe[`PFM_PORT1 + 7] = i2c_slave_select_a ? i2cs_out.clock_pull : i2cm_out[0].clock_pull;
        pri_oe[`PFM_PORT3 + 4] = i2c_slave_select_b ? i2cs_out.data_pull : i2cm_out[1].data_pull;
        pri_oe[`PFM_PORT3 + 5] = i2c_slave_select_b ? i2cs_out.clock_pull : i2cm_out[1].clock_pull;
        sec_out[`PFM_PORT3 + 4] = spim_out[2].select[1];
        sec_oe[`PFM_PORT3 + 4]  = 1'b1;
        sec_out[`PFM_PORT3 + 5] = spim_out[2].select[2];
        sec_oe[`PFM_PORT3 + 5]  = 1'b1;
        pri_out[`PFM_PORT3 + 6] = spim_out[1].select[1];
        pri_oe[`PFM_PORT3 + 6]  = 1'b1;
        pri_out[`PFM_PORT3 + 7] = spim_out[1].select[2];
        pri_oe[`PFM_PORT3 + 7]  = 1'b1;
        sec_out[`PFM_PORT3 + 6] = xip_out.select[1];
        sec_oe[`PFM_PORT3 + 6]  = 1'b1;
        sec_out[`PFM_PORT3 + 7] = xip_out.select[2];
        sec_oe[`PFM_PORT3 + 7]  = 1'b1;
        // Single-wire line is open drain; its pull-up enable is push-pull; slave-ready pins are inputs.
        pri_oe[`PFM_PORT4 + 0]  = swm_out.line_pull;
        pri_out[`PFM_PORT4 + 1] = swm_out.pullup_enable;
        pri_oe[`PFM_PORT4 + 1]  = 1'b1;
    end

    // One selector per pin; pulse-train and timer slots follow from the pin index.
    genvar gi;
    generate
        for (gi = 0; gi < `PFM_NUM_PINS; gi++) begin : g_pin
            pfm_pin_cell u_cell (
                .mode    (pin_mode[gi]),
                .has_sec (SEC_MASK[gi]),
                .gpio_out(gpio_out[gi]),
                .gpio_oe (gpio_oe[gi]),
                .pri_out (pri_out[gi]),
                .pri_oe  (pri_oe[gi]),
                .sec_out (sec_out[gi]),
                .sec_oe  (sec_oe[gi]),
                .pt_out  (pt_out[gi % `PFM_PT_SLOTS]),
                .tmr_out (timer_out[gi % `PFM_TMR_SLOTS]),
                .drv_out (drv_out[gi]),
                .drv_oe  (drv_oe[gi]),
                .pri_on  (pri_on[gi]),
                .sec_on  (sec_on[gi]),
                .tin_on  (tin_on[gi])
            );
        end
    endgenerate

    // Next state: pad drive plus every peripheral input, each with an idle level when unrouted.
    always_comb begin
        state_next          = state_reg;
        state_next.pad_out  = drv_out;
        state_next.pad_oe_n = ~drv_oe;
        for (int u = 0; u < 3; u++) begin
            // Option A is tested first so that it wins when both pins are enabled.
            state_next.uart_in[u].rx = pri_on[UART_BASE[u] + 0] ? pad_in[UART_BASE[u] + 0] :
                                       sec_on[UART_BASE[u] + 1] ? pad_in[UART_BASE[u] + 1] : `PFM_IDLE_RX;
            state_next.uart_in[u].cts = pri_on[UART_BASE[u] + 2] ? pad_in[UART_BASE[u] + 2] :
                                        sec_on[UART_BASE[u] + 3] ? pad_in[UART_BASE[u] + 3] : `PFM_IDLE_CTS;
        end
        state_next.spim_in = '0;
        state_next.xip_in  = '0;
        state_next.spim_in[0].lane_in[0] = pri_on[`PFM_PORT0 + 5] ? pad_in[`PFM_PORT0 + 5] : `PFM_IDLE_LANE;
        state_next.spim_in[0].lane_in[1] = pri_on[`PFM_PORT0 + 6] ? pad_in[`PFM_PORT0 + 6] : `PFM_IDLE_LANE;
        state_next.spim_in[2].lane_in[0] = pri_on[`PFM_PORT2 + 5] ? pad_in[`PFM_PORT2 + 5] : `PFM_IDLE_LANE;
        state_next.spim_in[2].lane_in[1] = pri_on[`PFM_PORT2 + 6] ? pad_in[`PFM_PORT2 + 6] : `PFM_IDLE_LANE;
        for (int l = 0; l < 4; l++) begin
            state_next.spim_in[1].lane_in[l] = pri_on[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)] ?
                                               pad_in[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)] : `PFM_IDLE_LANE;
            state_next.xip_in.lane_in[l] = sec_on[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)] ?
                                           pad_in[`PFM_PORT1 + ((l < 2) ? l + 1 : l + 2)] : `PFM_IDLE_LANE;
        end
        for (int s = 0; s < 2; s++) begin
            state_next.spim_in[2].slave_ready[s] = sec_on[`PFM_PORT4 + s] ? pad_in[`PFM_PORT4 + s] : `PFM_IDLE_SR;
        end
        // A master sees its pins only while it owns them; the slave prefers option A.
        state_next.i2cm_in[0].data  = (pri_on[`PFM_PORT1 + 6] && !i2c_slave_select_a) ? pad_in[`PFM_PORT1 + 6] : `PFM_IDLE_I2C;
        state_next.i2cm_in[0].clock = (pri_on[`PFM_PORT1 + 7] && !i2c_slave_select_a) ? pad_in[`PFM_PORT1 + 7] : `PFM_IDLE_I2C;
        state_next.i2cm_in[1].data  = (pri_on[`PFM_PORT3 + 4] && !i2c_slave_select_b) ? pad_in[`PFM_PORT3 + 4] : `PFM_IDLE_I2C;
        state_next.i2cm_in[1].clock = (pri_on[`PFM_PORT3 + 5] && !i2c_slave_select_b) ? pad_in[`PFM_PORT3 + 5] : `PFM_IDLE_I2C;
        if (pri_on[`PFM_PORT1 + 6] && i2c_slave_select_a) begin
            state_next.i2cs_in = {pad_in[`PFM_PORT1 + 6], pad_in[`PFM_PORT1 + 7]};
        end else if (pri_on[`PFM_PORT3 + 4] && i2c_slave_select_b) begin
            state_next.i2cs_in = {pad_in[`PFM_PORT3 + 4], pad_in[`PFM_PORT3 + 5]};
        end else begin
            state_next.i2cs_in = {`PFM_IDLE_I2C, `PFM_IDLE_I2C};
        end
        state_next.swm_in = pri_on[`PFM_PORT4 + 0] ? pad_in[`PFM_PORT4 + 0] : `PFM_IDLE_SWM;
        // Several pins share a timer slot; walking downward lets the lowest pin win.
        state_next.timer_in = {6{`PFM_IDLE_TMR}};
        for (int p = `PFM_NUM_PINS - 1; p >= 0; p--) begin
            if (tin_on[p]) begin
                state_next.timer_in[p % `PFM_TMR_SLOTS] = pad_in[p];
            end
        end
        // A port interrupt is the OR of its enabled pins at high level.
        state_next.port_irq = '0;
        for (int p = 0; p < `PFM_NUM_PINS; p++) begin
            if (irq_enable[p] && pad_in[p]) begin
                state_next.port_irq[p / `PFM_PORT_PINS] = 1'b1;
            end
        end
    end

    // All pads released and every peripheral input idle during reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg          <= '0;
            state_reg.pad_oe_n <= '1;
            state_reg.uart_in  <= {3{`PFM_IDLE_RX, `PFM_IDLE_CTS}};
            state_reg.i2cm_in  <= '1;
            state_reg.i2cs_in  <= '1;
            state_reg.swm_in   <= `PFM_IDLE_SWM;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pad_out  = state_reg.pad_out;
    assign pad_oe_n = state_reg.pad_oe_n;
    assign uart_in  = state_reg.uart_in;
    assign spim_in  = state_reg.spim_in;
    assign xip_in   = state_reg.xip_in;
    assign i2cm_in  = state_reg.i2cm_in;
    assign i2cs_in  = state_reg.i2cs_in;
    assign swm_in   = state_reg.swm_in;
    assign timer_in = state_reg.timer_in;
    assign port_irq = state_reg.port_irq;

    // Checks on the routing, each one cycle behind its cause.
    a_u0_tx_primary: assert property (@(posedge clk) disable iff (rst)
        pin_mode[1] == `PFM_MODE_PRI |=> pad_out[1] == $past(uart_out[0].tx) && !pad_oe_n[1])
        else $error("UART0 transmit not on port 0 pin 1.");
    a_u2_rts_second: assert property (@(posedge clk) disable iff (rst)
        pin_mode[26] == `PFM_MODE_SEC |=> pad_out[26] == $past(uart_out[2].rts) && !pad_oe_n[26])
        else $error("UART2 option B request-to-send wrong.");
    a_rx_option_a: assert property (@(posedge clk) disable iff (rst)
        pin_mode[16] == `PFM_MODE_PRI && pin_mode[17] == `PFM_MODE_SEC |=> uart_in[1].rx == $past(pad_in[16]))
        else $error("UART1 receive did not prefer option A.");
    a_xip_clock: assert property (@(posedge clk) disable iff (rst)
        pin_mode[8] == `PFM_MODE_SEC |=> pad_out[8] == $past(xip_out.clock))
        else $error("XIP clock not on port 1 pin 0.");
    a_sec_fallback: assert property (@(posedge clk) disable iff (rst)
        pin_mode[4] == `PFM_MODE_SEC |=> pad_out[4] == $past(gpio_out[4]) && pad_oe_n[4] == !$past(gpio_oe[4]))
        else $error("Pin without secondary left general-purpose control.");
    a_i2c_owner: assert property (@(posedge clk) disable iff (rst)
        pin_mode[14] == `PFM_MODE_PRI && i2c_slave_select_a && i2cs_out.data_pull |=> !pad_oe_n[14] && !pad_out[14])
        else $error("I2C slave did not pull shared data pin.");
    a_pulse_wrap: assert property (@(posedge clk) disable iff (rst)
        pin_mode[32] == `PFM_MODE_PT |=> pad_out[32] == $past(pt_out[0]))
        else $error("Port 4 pin 0 not on pulse-train output 0.");
    a_timer_slot: assert property (@(posedge clk) disable iff (rst)
        pin_mode[32] == `PFM_MODE_TIN && tin_on[8] == 1'b0 && tin_on[2] == 1'b0 && tin_on[14] == 1'b0 &&
        tin_on[20] == 1'b0 && tin_on[26] == 1'b0 |=> timer_in[2] == $past(pad_in[32]))
        else $error("Port 4 pin 0 does not feed timer 2.");
    a_port_irq: assert property (@(posedge clk) disable iff (rst)
        irq_enable[33] && pad_in[33] |=> port_irq[4])
        else $error("Port 4 interrupt missing.");
    a_swm_pullup: assert property (@(posedge clk) disable iff (rst)
        pin_mode[33] == `PFM_MODE_PRI |=> pad_out[33] == $past(swm_out.pullup_enable) && !pad_oe_n[33])
        else $error("Single-wire pull-up enable not on port 4 pin 1.");

endmodule : pfm_matrix

// File: dv/pfm_pads.sv
// Board-side model of the 34 port pins seen by the pin function matrix.
module pfm_pads (
    input  wire logic [33:0] pad_out,
    input  wire logic [33:0] pad_oe_n,
    input  wire logic [33:0] board,
    output logic [33:0]      pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // A driven pad reads back its own level; a released pad shows what the board puts on it.
    assign pad_in = (pad_out & ~pad_oe_n) | (board & pad_oe_n);
endmodule : pfm_pads

// File: dv/tb.sv
// Self-checking bench of the port pin function matrix.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; int sel; logic [33:0] e; logic [33:0] k; int due;} pfm_note_t;
    logic                          clk = 1'h0, rst = 1'h1, sel_a = 1'h0, sel_b = 1'h0, w_in;
    logic [33:0]                   pad_in, pad_out, pad_oe_n, e, r, g_out = '0, g_oe = '1, irq_en = '0, board = '0;
    logic [33:0][2:0]              mode = '0, m;
    pfm_pkg::pfm_uart_out_t [2:0]  u_out = '0;
    pfm_pkg::pfm_uart_in_t [2:0]   u_in;
    pfm_pkg::pfm_spi_out_t [2:0]   s_out = '0, sv;
    pfm_pkg::pfm_spi_in_t [2:0]    s_in, es;
    pfm_pkg::pfm_spi_out_t         x_out = '0, xv;
    pfm_pkg::pfm_spi_in_t          x_in, xe;
    pfm_pkg::pfm_i2c_out_t [1:0]   im_out = '0;
    pfm_pkg::pfm_i2c_in_t [1:0]    im_in, ie;
    pfm_pkg::pfm_i2c_out_t         is_out = '0;
    pfm_pkg::pfm_i2c_in_t          is_in, je;
    pfm_pkg::pfm_swm_out_t         w_out = '0;
    logic [15:0]                   pt = '0;
    logic [5:0]                    t_out = '0, t_in;
    logic [4:0]                    irq;
    int                            cyc = 0, fail_count = 0, num_checks = 0, b, tx, rx, rs, ct;
    pfm_note_t                     q[$];

    pfm_matrix pfm_matrix_i (.clk(clk), .rst(rst), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pin_mode(mode), .gpio_out(g_out), .gpio_oe(g_oe), .irq_enable(irq_en), .i2c_slave_select_a(sel_a),
        .i2c_slave_select_b(sel_b), .uart_out(u_out), .uart_in(u_in), .spim_out(s_out), .spim_in(s_in),
        .xip_out(x_out), .xip_in(x_in), .i2cm_out(im_out), .i2cm_in(im_in), .i2cs_out(is_out),
        .i2cs_in(is_in), .swm_out(w_out), .swm_in(w_in), .pt_out(pt), .timer_out(t_out), .timer_in(t_in),
        .port_irq(irq));
    pfm_pads pfm_pads_i (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .board(board), .pad_in(pad_in));

    // Clock and edge counter; notes are due a fixed number of edges after they are written.
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic note(string nm, int sel, logic [33:0] ev, logic [33:0] k, int lag = 3);
        q.push_back(pfm_note_t'{nm, sel, ev, k, cyc + lag});
    endtask : note

    task automatic check_vec(pfm_note_t n);
        logic [33:0] got;
        case (n.sel)
            0: got = pad_out;
            1: got = pad_oe_n;
            2: got = 34'(u_in);
            3: got = 34'(t_in);
            5: got = 34'({s_in, x_in, im_in, is_in, w_in});
            default: got = 34'(irq);
        endcase
        num_checks++;
        if ((got & n.k) !== (n.e & n.k)) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n.nm, n.e & n.k, got & n.k);
        end
    endtask : check_vec

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Holding each setting three edges lets pad drive changes settle before pads are sampled back.
    task automatic fin(string s);
        repeat (3) @(posedge clk);
        $display("test %s done", s);
    endtask : fin

    // Monitor: just after each edge, compare the notes that have come due, oldest first.
    always @(posedge clk) begin
        #1;
        while (q.size() != 0 && q[0].due == cyc) begin
            check_vec(q.pop_front());
        end
    end

    // Watchdog: the tests take under a hundred cycles, far below its 5000.
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(85997));
        note("reset oe", 1, '1, '1, 2);
        note("reset uart in", 2, 34'h3f, 34'h3f, 2);
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        fin("reset");
        for (int u = 0; u < 3; u++) for (int s = 1; s < 3; s++) begin
            @(posedge clk);
            b = (u == 0) ? 0 : 8 * u + 8;
            tx = b + 2 - s;
            rx = b + s - 1;
            rs = b + 4 - s;
            ct = b + 1 + s;
            m = '0;
            for (int k = 0; k < 4; k++) m[b + k] = 3'(s);
            e = 34'({$urandom, $urandom});
            r = 34'({$urandom, $urandom});
            mode <= m;
            board <= e;
            u_out <= r[5:0];
            note("uart pad", 0, 34'(r[2*u+1]) << tx | 34'(r[2*u]) << rs, 34'h1 << tx | 34'h1 << rs);
            note("uart oe", 1, '0, 34'h1 << tx | 34'h1 << rs);
            note("uart in", 2, 34'({e[rx], e[ct]}) << 2 * u, 34'h3 << 2 * u);
            fin("uart");
        end
        @(posedge clk);
        m = '0;
        m[4] = 3'h1;
        m[20] = 3'h1;
        m[8] = 3'h2;
        m[5] = 3'h2;
        sv = 36'({$urandom, $urandom});
        xv = 12'($urandom);
        r = 34'({$urandom, $urandom});
        mode <= m;
        s_out <= sv;
        x_out <= xv;
        g_out <= r;
        g_oe <= ~r;
        e = '0;
        e[4] = sv[0].clock;
        e[20] = sv[2].clock;
        e[8] = xv.clock;
        e[5] = r[5];
        note("spi pad", 0, e, 34'h100130);
        note("spi oe", 1, 34'(r[5]) << 5, 34'h100130);
        fin("spi and empty secondary");
        for (int s = 3; s < 5; s++) begin
            @(posedge clk);
            r = 34'({$urandom, $urandom});
            mode <= {34{3'(s)}};
            pt <= r[15:0];
            t_out <= r[21:16];
            for (int i = 0; i < 34; i++) e[i] = (s == 3) ? r[i % 16] : r[16 + i % 6];
            note("pulse timer pad", 0, e, '1);
            note("pulse timer oe", 1, '0, '1);
            fin("pulse and timer out");
        end
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            m = '0;
            m[32] = 3'h5;
            m[33] = 3'h5;
            for (int i = 6; i < 12; i++) m[i] = (v == 0) ? 3'h5 : 3'h0;
            e = 34'({$urandom, $urandom});
            mode <= m;
            board <= e;
            note("timer in", 3, (v == 0) ? 34'(e[11:6]) : 34'(e[33:32]) << 2, 34'h3f);
            fin("timer in");
        end
        repeat (4) begin
            @(posedge clk);
            r = 34'({$urandom, $urandom});
            e = 34'({$urandom, $urandom});
            mode <= '0;
            g_oe <= '0;
            irq_en <= r;
            board <= e;
            r = r & e;
            note("port irq", 4, 34'({|r[33:32], |r[31:24], |r[23:16], |r[15:8], |r[7:0]}), 34'h1f);
            fin("port irq");
        end
        repeat (4) begin
            @(posedge clk);
            m = '0;
            m[14] = 3'h1;
            m[15] = 3'h1;
            m[28] = 3'h1;
            m[29] = 3'h1;
            r = 34'($urandom);
            r[7] = r[7] & ~r[6];
            mode <= m;
            sel_a <= r[6];
            sel_b <= r[7];
            im_out <= r[3:0];
            is_out <= r[5:4];
            e = '0;
            e[15:14] = r[6] ? ~{r[4], r[5]} : ~{r[0], r[1]};
            e[29:28] = r[7] ? ~{r[4], r[5]} : ~{r[2], r[3]};
            note("i2c oe", 1, e, 34'h3000c000);
            note("i2c pad", 0, '0, 34'h3000c000);
            fin("i2c owner");
        end
        // SPI, XIP, I2C and single-wire inputs plus UART1 receive in all-primary and all-secondary use; pin 17 stays on option B receive.
        for (int s = 1; s < 3; s++) begin
            @(posedge clk);
            e = 34'({$urandom, $urandom});
            r = 34'($urandom);
            m = {34{3'(s)}};
            m[17] = 3'h2;
            mode <= m;
            board <= e;
            s_out <= '0;
            x_out <= '0;
            im_out <= '0;
            is_out <= '0;
            sel_a <= r[0];
            sel_b <= r[1];
            es = '0;
            xe = '0;
            if (s == 1) begin
                es[0].lane_in[1:0] = {e[6], e[5]};
                es[1].lane_in = {e[13], e[12], e[10], e[9]};
                es[2].lane_in[1:0] = {e[22], e[21]};
            end else begin
                xe.lane_in = {e[13], e[12], e[10], e[9]};
                es[2].slave_ready = e[33:32];
            end
            ie = (s == 1) ? {r[1] ? 2'h3 : {e[28], e[29]}, r[0] ? 2'h3 : {e[14], e[15]}} : 4'hf;
            je = (s != 1) ? 2'h3 : r[0] ? {e[14], e[15]} : r[1] ? {e[28], e[29]} : 2'h3;
            note("periph in", 5, 34'({es, xe, ie, je, (s == 1) ? e[32] : 1'h1}), 34'h7fff_ffff);
            note("uart rx option", 2, 34'((s == 1) ? e[16] : e[17]) << 3, 34'h8);
            fin("peripheral inputs");
        end
        tally_and_finish();
    end
endmodule : tb
